/* File: hw/pcd_coder.sv */
// serial checksum register and whitening sequence generator
`timescale 1ns/1ps
`include "pcd_defs.svh"
module pcd_coder
   import pcd_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // control
   input  wire logic        init,
   input  wire logic        adv,
   input  wire logic        crc_upd,
   input  wire logic        bit_in,
   // state
   output logic      [15:0] crc_ff,
   output logic      [8:0]  wht_ff
);
   logic fb;

   assign fb = crc_ff[15] ^ bit_in;

   // msb-first serial form; a nonzero preset makes leading zeros count
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_ff <= `PCD_CRC_SEED;
      end else if (init) begin
         crc_ff <= `PCD_CRC_SEED;
      end else if (adv && crc_upd) begin
         crc_ff <= {crc_ff[14:0], 1'b0} ^ (fb ? `PCD_CRC_POLY : 16'h0000);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wht_ff <= `PCD_WHT_SEED;
      end else if (init) begin
         wht_ff <= `PCD_WHT_SEED;
      end else if (adv) begin
         wht_ff <= {wht_ff[0] ^ wht_ff[`PCD_WHT_TAP], wht_ff[8:1]};
      end
   end
endmodule : pcd_coder

/* File: hw/pcd_defs.svh */
// register offsets, field positions, reset values and coding constants of the packet coder
`ifndef PCD_DEFS_SVH
`define PCD_DEFS_SVH

// register indices; byte address is four times the index
`define PCD_IDX_FIFO      8'h00
`define PCD_IDX_MODUL     8'h02
`define PCD_IDX_RATE_HI   8'h03
`define PCD_IDX_RATE_LO   8'h04
`define PCD_IDX_PKT_CFG1  8'h37
`define PCD_IDX_PAY_LEN   8'h38
`define PCD_IDX_CTRL      8'h40
`define PCD_IDX_IRQ_ST    8'h41
`define PCD_IDX_IRQ_CLR   8'h42
`define PCD_IDX_IRQ_EN    8'h43

// reset values
`define PCD_RST_MODUL     8'h00
`define PCD_RST_RATE_HI   8'h1a
`define PCD_RST_RATE_LO   8'h0b
`define PCD_RST_PKT_CFG1  8'h10
`define PCD_RST_PAY_LEN   8'h40

// fields
`define PCD_MODE_MSB      6
`define PCD_MODE_LSB      5
`define PCD_MODE_PACKET   2'h0
`define PCD_DCB_MSB       6
`define PCD_DCB_LSB       5
`define PCD_DCB_MAN       2'h1
`define PCD_DCB_WHT       2'h2
`define PCD_CRC_ON_BIT    4
`define PCD_KEEP_BIT      3
`define PCD_TX_GO_BIT     0
`define PCD_ST_PAY        0
`define PCD_ST_SENT       1
`define PCD_ST_PASS       2

// coding constants
`define PCD_CRC_POLY      16'h1021
`define PCD_CRC_SEED      16'h1d0f
`define PCD_WHT_SEED      9'h1ff
`define PCD_WHT_TAP       5
`define PCD_FIFO_DEPTH    7'h40

`endif

/* File: hw/pcd_pkg.sv */
// types shared by the packet coder modules
package pcd_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_TX_LOAD, ST_TX_SEND, ST_RX_DATA, ST_RX_CHECK} pcd_eng_state_t;
   typedef logic [7:0] pcd_byte_t;
endpackage : pcd_pkg

/* File: hw/pcd_top.sv */
// packet checksum and dc balancing stage with apb registers and payload fifo
`timescale 1ns/1ps
`include "pcd_defs.svh"
module pcd_top
   import pcd_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata_ff,
   output logic             pready_ff,
   output logic             pslverr_ff,
   // interrupt
   output logic             irq_ff,
   // modem transmit side
   output logic             chip_tick_ff,
   output logic             tx_chip_ff,
   output logic             tx_chip_valid_ff,
   output logic             tx_second_chip_ff,
   output logic             tx_busy_ff,
   // modem receive side
   input  wire logic        rx_payload_start,
   input  wire logic        rx_chip,
   input  wire logic        rx_chip_valid
);
   pcd_eng_state_t state_ff;
   pcd_byte_t      rx_byte_ff, wdata, mem_ff [0:63];
   logic [31:0]    rdata;
   logic [15:0]    sh_ff, div_cnt_ff, crc_ff;
   logic [8:0]     wht_ff;
   logic [7:0]     modul_ff, rate_hi_ff, rate_lo_ff, cfg1_ff, pay_len_ff, byte_cnt_ff, idx;
   logic [6:0]     cnt_ff;
   logic [5:0]     wr_ptr_ff, rd_ptr_ff;
   logic [3:0]     bit_cnt_ff;
   logic [2:0]     st_ff, en_ff, ev, clr_mask;
   logic           pass_ff, in_crc_ff, half_ff, first_ff, rx_push_ff, hit, acc, fin, wr_en, rd_en;
   logic           man_on, wht_on, crc_on, keep_on, tx_act, rx_act, tx_go, rx_go, tx_pop, apb_push, apb_pop;
   logic           push, pop, fifo_empty, fifo_full, fifo_clr, div_wrap, w_bit, tx_bit, rx_bit, tx_step, rx_step;
   logic           chk, rx_match, tx_end;
   // apb decode; one wait state so read data comes from a flop
   assign idx   = paddr[9:2];
   assign hit   = (paddr[11:10] == 2'h0) && (idx inside {`PCD_IDX_FIFO, `PCD_IDX_MODUL, `PCD_IDX_RATE_HI,
                  `PCD_IDX_RATE_LO, `PCD_IDX_PKT_CFG1, `PCD_IDX_PAY_LEN, `PCD_IDX_CTRL, `PCD_IDX_IRQ_ST,
                  `PCD_IDX_IRQ_CLR, `PCD_IDX_IRQ_EN});
   assign acc   = psel & penable & ~pready_ff;
   assign fin   = psel & penable & pready_ff;
   assign wr_en = fin & pwrite & pstrb[0] & hit;
   assign rd_en = fin & ~pwrite & hit;
   // coding modes; select 11 enables neither method
   assign man_on  = (cfg1_ff[`PCD_DCB_MSB:`PCD_DCB_LSB] == `PCD_DCB_MAN)
                    && (modul_ff[`PCD_MODE_MSB:`PCD_MODE_LSB] == `PCD_MODE_PACKET);
   assign wht_on  = cfg1_ff[`PCD_DCB_MSB:`PCD_DCB_LSB] == `PCD_DCB_WHT;
   assign crc_on  = cfg1_ff[`PCD_CRC_ON_BIT];
   assign keep_on = cfg1_ff[`PCD_KEEP_BIT];
   assign tx_act = (state_ff == ST_TX_LOAD) || (state_ff == ST_TX_SEND);
   assign rx_act = (state_ff == ST_RX_DATA) || (state_ff == ST_RX_CHECK);
   assign tx_go  = wr_en && (idx == `PCD_IDX_CTRL) && pwdata[`PCD_TX_GO_BIT] && (state_ff == ST_IDLE);
   assign rx_go  = (state_ff == ST_IDLE) && rx_payload_start && !tx_go;
   // fifo ports; the engine has priority over software
   assign fifo_empty = cnt_ff == 7'h00;
   assign fifo_full  = cnt_ff == `PCD_FIFO_DEPTH;
   assign tx_pop     = (state_ff == ST_TX_LOAD) && (byte_cnt_ff != 8'h00) && !fifo_empty;
   assign apb_push   = wr_en && (idx == `PCD_IDX_FIFO) && !rx_act;
   assign apb_pop    = rd_en && (idx == `PCD_IDX_FIFO) && !fifo_empty && !tx_pop;
   assign push       = (rx_push_ff | apb_push) & ~fifo_full;
   assign pop        = tx_pop | apb_pop;
   assign wdata      = rx_push_ff ? rx_byte_ff : pwdata[7:0];
   // bit level coding, fifo side always plain nrz
   assign w_bit    = wht_on & wht_ff[0];
   assign tx_bit   = sh_ff[15] ^ w_bit;
   assign rx_bit   = (man_on ? first_ff : rx_chip) ^ w_bit;
   assign tx_step  = (state_ff == ST_TX_SEND) && chip_tick_ff && (!man_on || half_ff);
   assign rx_step  = (state_ff == ST_RX_DATA) && rx_chip_valid && (!man_on || half_ff);
   assign chk      = state_ff == ST_RX_CHECK;
   assign rx_match = sh_ff == ~crc_ff;
   assign tx_end   = (state_ff == ST_TX_LOAD) && (byte_cnt_ff == 8'h00) && !(crc_on && !in_crc_ff);
   assign fifo_clr = chk && crc_on && !rx_match && !keep_on;
   pcd_coder u_coder (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .init    (tx_go | rx_go),
      .adv     (tx_step | rx_step),
      .crc_upd (crc_on & ~in_crc_ff),
      .bit_in  ((state_ff == ST_TX_SEND) ? sh_ff[15] : rx_bit),
      .crc_ff  (crc_ff),
      .wht_ff  (wht_ff)
   );
   // chip rate divider; the modem times preamble and sync from the same tick
   assign div_wrap = ({1'b0, div_cnt_ff} + 17'h00001) >= {1'b0, rate_hi_ff, rate_lo_ff};
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_ff   <= 16'h0000;
         chip_tick_ff <= 1'b0;
      end else begin
         div_cnt_ff   <= div_wrap ? 16'h0000 : div_cnt_ff + 16'h0001;
         chip_tick_ff <= div_wrap;
      end
   end

   // packet engine; a divider below 2 may lose a tick during a byte load
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff    <= ST_IDLE;
         sh_ff       <= 16'h0000;
         bit_cnt_ff  <= 4'h0;
         byte_cnt_ff <= 8'h00;
         in_crc_ff   <= 1'b0;
         half_ff     <= 1'b0;
         first_ff    <= 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               half_ff   <= 1'b0;
               in_crc_ff <= 1'b0;
               if (tx_go) begin
                  byte_cnt_ff <= pay_len_ff;
                  state_ff    <= ST_TX_LOAD;
               end else if (rx_go) begin
                  byte_cnt_ff <= 8'h00;
                  bit_cnt_ff  <= 4'h7;
                  state_ff    <= ST_RX_DATA;
               end
            end
            ST_TX_LOAD: begin
               if (tx_pop) begin
                  sh_ff       <= {mem_ff[rd_ptr_ff], 8'h00};
                  bit_cnt_ff  <= 4'h7;
                  byte_cnt_ff <= byte_cnt_ff - 8'h01;
                  state_ff    <= ST_TX_SEND;
               end else if (byte_cnt_ff == 8'h00 && crc_on && !in_crc_ff) begin
                  sh_ff      <= ~crc_ff;
                  bit_cnt_ff <= 4'hf;
                  in_crc_ff  <= 1'b1;
                  state_ff   <= ST_TX_SEND;
               end else if (tx_end) begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_TX_SEND: begin
               if (chip_tick_ff) begin
                  if (man_on && !half_ff) begin
                     half_ff <= 1'b1;
                  end else begin
                     half_ff <= 1'b0;
                     sh_ff   <= {sh_ff[14:0], 1'b0};
                     if (bit_cnt_ff == 4'h0) begin
                        state_ff <= ST_TX_LOAD;
                     end else begin
                        bit_cnt_ff <= bit_cnt_ff - 4'h1;
                     end
                  end
               end
            end
            ST_RX_DATA: begin
               if (rx_chip_valid) begin
                  if (man_on && !half_ff) begin
                     half_ff  <= 1'b1;
                     first_ff <= rx_chip;
                  end else begin
                     half_ff    <= 1'b0;
                     sh_ff      <= {sh_ff[14:0], rx_bit};
                     bit_cnt_ff <= bit_cnt_ff - 4'h1;
                     if (bit_cnt_ff == 4'h0) begin
                        if (in_crc_ff) begin
                           state_ff <= ST_RX_CHECK;
                        end else begin
                           byte_cnt_ff <= byte_cnt_ff + 8'h01;
                           if (8'(byte_cnt_ff + 8'h01) == pay_len_ff) begin
                              if (crc_on) begin
                                 in_crc_ff  <= 1'b1;
                                 bit_cnt_ff <= 4'hf;
                              end else begin
                                 state_ff <= ST_RX_CHECK;
                              end
                           end else begin
                              bit_cnt_ff <= 4'h7;
                           end
                        end
                     end
                  end
               end
            end
            ST_RX_CHECK: state_ff <= ST_IDLE;
            default:     state_ff <= ST_IDLE;
         endcase
      end
   end
   // only payload bytes reach the fifo
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_push_ff <= 1'b0;
         rx_byte_ff <= 8'h00;
      end else begin
         rx_push_ff <= rx_step && (bit_cnt_ff == 4'h0) && !in_crc_ff;
         rx_byte_ff <= {sh_ff[6:0], rx_bit};
      end
   end
   // modem transmit chips
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_chip_valid_ff  <= 1'b0;
         tx_chip_ff        <= 1'b0;
         tx_second_chip_ff <= 1'b0;
         tx_busy_ff        <= 1'b0;
      end else begin
         tx_chip_valid_ff <= (state_ff == ST_TX_SEND) && chip_tick_ff;
         tx_busy_ff       <= tx_act;
         if ((state_ff == ST_TX_SEND) && chip_tick_ff) begin
            tx_chip_ff        <= (man_on && half_ff) ? ~tx_bit : tx_bit;
            tx_second_chip_ff <= man_on & half_ff;
         end
      end
   end
   // payload fifo
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= 6'h00;
         rd_ptr_ff <= 6'h00;
         cnt_ff    <= 7'h00;
      end else if (fifo_clr) begin
         wr_ptr_ff <= 6'h00;
         rd_ptr_ff <= 6'h00;
         cnt_ff    <= 7'h00;
      end else begin
         wr_ptr_ff <= push ? wr_ptr_ff + 6'h01 : wr_ptr_ff;
         rd_ptr_ff <= pop ? rd_ptr_ff + 6'h01 : rd_ptr_ff;
         cnt_ff    <= 7'(cnt_ff + {6'h00, push} - {6'h00, pop});
      end
   end
   // events; a set in the clear cycle wins
   assign ev[`PCD_ST_PAY]  = chk && (!crc_on || rx_match || keep_on);
   assign ev[`PCD_ST_SENT] = tx_end;
   assign ev[`PCD_ST_PASS] = chk && crc_on && rx_match;
   assign clr_mask = (wr_en && idx == `PCD_IDX_IRQ_CLR) ? pwdata[2:0] : 3'h0;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff   <= 3'h0;
         pass_ff <= 1'b0;
         irq_ff  <= 1'b0;
      end else begin
         st_ff  <= (st_ff & ~clr_mask) | ev;
         irq_ff <= |(st_ff & en_ff);
         if (chk && crc_on) begin
            pass_ff <= rx_match;
         end
      end
   end
   // configuration registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         modul_ff   <= `PCD_RST_MODUL;
         rate_hi_ff <= `PCD_RST_RATE_HI;
         rate_lo_ff <= `PCD_RST_RATE_LO;
         cfg1_ff    <= `PCD_RST_PKT_CFG1;
         pay_len_ff <= `PCD_RST_PAY_LEN;
         en_ff      <= 3'h0;
      end else if (wr_en) begin
         case (idx)
            `PCD_IDX_MODUL:    modul_ff   <= pwdata[7:0];
            `PCD_IDX_RATE_HI:  rate_hi_ff <= pwdata[7:0];
            `PCD_IDX_RATE_LO:  rate_lo_ff <= pwdata[7:0];
            `PCD_IDX_PKT_CFG1: cfg1_ff    <= pwdata[7:0];
            `PCD_IDX_PAY_LEN:  pay_len_ff <= pwdata[7:0];
            `PCD_IDX_IRQ_EN:   en_ff      <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      case (idx)
         `PCD_IDX_FIFO:     rdata = {24'h0, mem_ff[rd_ptr_ff]};
         `PCD_IDX_MODUL:    rdata = {24'h0, modul_ff};
         `PCD_IDX_RATE_HI:  rdata = {24'h0, rate_hi_ff};
         `PCD_IDX_RATE_LO:  rdata = {24'h0, rate_lo_ff};
         `PCD_IDX_PKT_CFG1: rdata = {24'h0, cfg1_ff};
         `PCD_IDX_PAY_LEN:  rdata = {24'h0, pay_len_ff};
         `PCD_IDX_CTRL:     rdata = {28'h0, pass_ff, rx_act, tx_act, 1'b0};
         `PCD_IDX_IRQ_ST:   rdata = {29'h0, st_ff};
         `PCD_IDX_IRQ_EN:   rdata = {29'h0, en_ff};
         default:           rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= acc;
         pslverr_ff <= acc & ~hit;
         if (acc) begin
            prdata_ff <= (hit && !pwrite) ? rdata : 32'h0000_0000;
         end
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_bad_drop;
      chk && crc_on && !rx_match && !keep_on ##1 (cnt_ff == 7'h00);
   endsequence
   property p_no_crc_check;
      (chk && !crc_on) |=> st_ff[`PCD_ST_PAY] && (pass_ff == $past(pass_ff));
   endproperty
   a_no_crc_check: assert property (p_no_crc_check) else $error("payload event missing without checksum");
   property p_tx_crc_load;
      (state_ff == ST_TX_LOAD && byte_cnt_ff == 8'h00 && crc_on && !in_crc_ff)
         |=> (sh_ff == ~$past(crc_ff)) && (bit_cnt_ff == 4'hf) && (state_ff == ST_TX_SEND);
   endproperty
   a_tx_crc_load: assert property (p_tx_crc_load) else $error("checksum not appended");
   property p_rx_pass;
      (chk && crc_on && rx_match) |=> pass_ff && st_ff[`PCD_ST_PASS] && st_ff[`PCD_ST_PAY];
   endproperty
   a_rx_pass: assert property (p_rx_pass) else $error("pass flag not recorded");
   property p_bad_drop;
      (chk && crc_on && !rx_match && !keep_on) |-> s_bad_drop ##0 !$rose(st_ff[`PCD_ST_PAY]);
   endproperty
   a_bad_drop: assert property (p_bad_drop) else $error("failed packet not dropped");
   property p_bad_keep;
      (chk && crc_on && !rx_match && keep_on) |=> st_ff[`PCD_ST_PAY] && !pass_ff && (cnt_ff >= $past(cnt_ff));
   endproperty
   a_bad_keep: assert property (p_bad_keep) else $error("failed packet not kept");
   property p_push_payload;
      rx_push_ff |-> !$past(in_crc_ff) && $past(state_ff) == ST_RX_DATA;
   endproperty
   a_push_payload: assert property (p_push_payload) else $error("checksum byte pushed");
   property p_seed;
      (tx_go || rx_go) |=> (crc_ff == `PCD_CRC_SEED) && (wht_ff == `PCD_WHT_SEED);
   endproperty
   a_seed: assert property (p_seed) else $error("packet seeds wrong");
   property p_man_pair;
      (tx_chip_valid_ff && tx_second_chip_ff) |-> (tx_chip_ff != $past(tx_chip_ff));
   endproperty
   a_man_pair: assert property (p_man_pair) else $error("manchester pair not complementary");
   property p_chip_rate;
      tx_chip_valid_ff |-> $past(chip_tick_ff) && $past(state_ff) == ST_TX_SEND;
   endproperty
   a_chip_rate: assert property (p_chip_rate) else $error("chip off the programmed rate");
   property p_whiten;
      (state_ff == ST_TX_SEND && chip_tick_ff && !man_on && wht_on)
         |=> tx_chip_ff == ($past(sh_ff[15]) ^ $past(wht_ff[0]));
   endproperty
   a_whiten: assert property (p_whiten) else $error("whitened chip wrong");
endmodule : pcd_top

/* File: testbench/pcd_remote.sv */
// remote transceiver model: records sent chips, feeds received chips
`timescale 1ns/1ps
module pcd_remote (
   // clock
   input  wire logic ref_clk,
   // chips from the coder
   input  wire logic tx_chip,
   input  wire logic tx_chip_valid,
   // chips to the coder
   output logic      rx_payload_start,
   output logic      rx_chip,
   output logic      rx_chip_valid
);
   bit got[$];

   initial begin
      rx_payload_start = 1'b0;
      rx_chip          = 1'b0;
      rx_chip_valid    = 1'b0;
   end

   always @(posedge ref_clk) begin
      if (tx_chip_valid === 1'b1) got.push_back(tx_chip);
   end

   // uneven spacing; inverse level between chips so a stale chip cannot pass
   task automatic send(input bit c[$]);
      rx_payload_start <= 1'b1;
      @(posedge ref_clk) rx_payload_start <= 1'b0;
      foreach (c[i]) begin
         repeat ($urandom_range(3, 1)) @(posedge ref_clk);
         rx_chip       <= c[i];
         rx_chip_valid <= 1'b1;
         @(posedge ref_clk) rx_chip_valid <= 1'b0;
         rx_chip <= !c[i];
      end
   endtask : send
endmodule : pcd_remote

/* File: testbench/tb_top.sv */
// self-checking bench for the packet coder
`timescale 1ns/1ps
module tb_top;
   typedef logic [7:0] pcd_bq_t[$];
   typedef bit         pcd_cq_t[$];
   logic        ref_clk, rst_n, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_ff;
   logic [3:0]  pstrb;
   logic        pready_ff, pslverr_ff, irq_ff, tx_chip_ff, tx_chip_valid_ff, tx_busy_ff;
   logic        chip_tick_ff, tx_second_chip_ff;
   int          last_tick, sec_n;
   bit          pass_exp;
   logic        rx_payload_start, rx_chip, rx_chip_valid;
   int          fails, cmp_count, cyc;

   pcd_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
      .pslverr_ff(pslverr_ff), .irq_ff(irq_ff), .chip_tick_ff(chip_tick_ff), .tx_chip_ff(tx_chip_ff),
      .tx_chip_valid_ff(tx_chip_valid_ff), .tx_second_chip_ff(tx_second_chip_ff), .tx_busy_ff(tx_busy_ff),
      .rx_payload_start(rx_payload_start), .rx_chip(rx_chip), .rx_chip_valid(rx_chip_valid));
   pcd_remote rem (.ref_clk(ref_clk), .tx_chip(tx_chip_ff), .tx_chip_valid(tx_chip_valid_ff),
      .rx_payload_start(rx_payload_start), .rx_chip(rx_chip), .rx_chip_valid(rx_chip_valid));

   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test

   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // while sending, ticks follow the programmed divider of 2; count second chips of pairs
   always @(posedge ref_clk) begin
      if (chip_tick_ff === 1'b1) begin
         if (tx_busy_ff === 1'b1) chk("tick gap", cyc - last_tick, 2);
         last_tick = cyc;
      end
      if (tx_chip_valid_ff === 1'b1 && tx_second_chip_ff === 1'b1) sec_n++;
   end

   task automatic apb(bit w, logic [7:0] a, logic [7:0] d, output logic [31:0] r);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {2'h0, a, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge ref_clk) penable <= 1'b1;
      do @(posedge ref_clk); while (pready_ff !== 1'b1);
      err = pslverr_ff;
      r   = prdata_ff;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task automatic wr(logic [7:0] a, d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr

   task automatic rd(logic [7:0] a, e);
      logic [31:0] r;
      apb(1'b0, a, 8'h00, r);
      chk($sformatf("reg %h", a), r, {24'h0, e});
   endtask : rd

   // reference chip stream: checksum over plain payload, then balancing per bit
   function automatic pcd_cq_t enc(pcd_bq_t b, int m, bit ce);
      logic [15:0] c;
      logic [8:0]  l;
      logic        x;
      pcd_cq_t     q;
      c = 16'h1d0f;
      l = 9'h1ff;
      foreach (b[i]) for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? 16'h1021 : 16'h0);
      if (ce) begin
         b.push_back(~c[15:8]);
         b.push_back(~c[7:0]);
      end
      foreach (b[i]) for (int k = 7; k >= 0; k--) begin
         x = b[i][k];
         if (m == 2) begin
            x = x ^ l[0];
            l = {l[0] ^ l[5], l[8:1]};
         end
         q.push_back(x);
         if (m == 1) q.push_back(!x);
      end
      return q;
   endfunction : enc

   task automatic txp(int m);
      pcd_bq_t b;
      pcd_cq_t q;
      repeat (3) begin
         b.push_back(8'($urandom));
         wr(8'h00, b[$]);
      end
      rem.got.delete();
      sec_n = 0;
      wr(8'h40, 8'h01);
      repeat (2) @(posedge ref_clk);
      while (tx_busy_ff !== 1'b0) @(posedge ref_clk);
      repeat (4) @(posedge ref_clk);
      q = enc(b, m % 3, m < 3);
      chk("chip count", rem.got.size(), q.size());
      foreach (q[i]) chk("chip", rem.got[i], q[i]);
      chk("second chips", sec_n, m == 1 ? q.size() / 2 : 0);
      rd(8'h41, 8'h02);
      wr(8'h42, 8'h02);
   endtask : txp

   task automatic rxp(int m, bit bad, logic [7:0] st);
      pcd_bq_t b;
      pcd_cq_t q;
      repeat (3) b.push_back(8'($urandom));
      q = enc(b, m % 3, m < 3);
      if (bad) q[q.size()-1] ^= 1'b1;
      rem.send(q);
      repeat (6) @(posedge ref_clk);
      rd(8'h41, st);
      if (m < 3) pass_exp = !bad;
      rd(8'h40, {4'h0, pass_exp, 3'h0});
      chk("irq", irq_ff, st[0]);
      if (st[0]) foreach (b[i]) rd(8'h00, b[i]);
      wr(8'h42, 8'h07);
      rd(8'h41, 8'h00);
      chk("irq clear", irq_ff, 1'b0);
   endtask : rxp

   initial begin
      ref_clk = 1'b0;
      rst_n   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      pstrb   = 4'hf;
      void'($urandom(32'h14db04c4));
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h1a);
      rd(8'h04, 8'h0b);
      rd(8'h37, 8'h10);
      rd(8'h38, 8'h40);
      rd(8'h10, 8'h00);
      chk("slverr", err, 1'b1);
      wr(8'h03, 8'h00);
      wr(8'h04, 8'h02);
      wr(8'h38, 8'h03);
      // a write without the low strobe must not land
      pstrb <= 4'h0;
      wr(8'h38, 8'h55);
      pstrb <= 4'hf;
      rd(8'h38, 8'h03);
      wr(8'h43, 8'h01);
      for (int m = 0; m < 4; m++) begin
         wr(8'h37, m < 3 ? 8'h10 | 8'(m << 5) : 8'h00);
         txp(m);
         rxp(m, 1'b0, m < 3 ? 8'h05 : 8'h01);
      end
      wr(8'h37, 8'h10);
      rxp(0, 1'b1, 8'h00);
      wr(8'h37, 8'h18);
      rxp(0, 1'b1, 8'h01);
      rxp(0, 1'b0, 8'h05);
      // manchester select outside packet mode, then select 11: both send plain chips
      wr(8'h02, 8'h20);
      wr(8'h37, 8'h30);
      txp(0);
      wr(8'h02, 8'h00);
      wr(8'h37, 8'h70);
      txp(0);
      finish_test();
   end
endmodule : tb_top
